// File: rtl/dmh_ctrl_consts.svh
// Constants for the main-loop mode and holdover controller
// Functional notes
// - Locked is entered only from pre-locked, pre-locked2 or lost-phase.
// - Lock from pre-locked or pre-locked2 needs a selected reference and one second of unbroken phase lock.
// - Loss of phase lock moves to lost-phase; regained lock returns to locked.
// - Lost-phase disqualifies on bucket trigger, or after 100 s with phase alarm.
// - Disqualification goes to pre-locked2 with good standby, else holdover.
// - Invalid reference with no replacement enters holdover using stored frequency.
// - Manual-holdover bit low selects automatic, high selects manual holdover.
// - Averaging bit high uses averaged frequency, low uses frozen frequency.
// - Averaged frequency is IIR filtered; short bit gives about 8 min, else 110 min; code time constant is 64 or 1024 averaging ticks (one per second by default).
// - Instantaneous holdover freezes the integral path value, or the mini-holdover value if mini-holdover is active; proportional path excluded.
// - Manual holdover uses the 19-bit signed offset register value.
// - Live frequency status reports the integral path offset, same format.
// - Filtered readback makes offset register reads return the averaged value, always.
// - Missing input freezes loop frequency quickly by entering mini-holdover.
// - A two-bit field selects one of four mini-holdover frequency methods.
// - Mini-holdover ends on new source, holdover entry, or input recovery.
// - Holdover moves to pre-locked2 once a reference is selected and applied.
// - Revertive mode enters pre-locked2 when a higher-priority reference returns.
// - No lock within 100 s in pre-locked2 returns to holdover and reselects.
// - Operating status register shows the main-loop state as a 3-bit code.
// - After reset the state machine starts in free-run.
// - Free-run moves to pre-locked when a reference is selected.
// - No lock within 100 s in pre-locked reverts to free-run and reselects.
`ifndef DMH_CTRL_CONSTS_SVH
`define DMH_CTRL_CONSTS_SVH
`define DMH_CLK_HZ       25000000
`define DMH_SEC_CYCLES   (`DMH_CLK_HZ * 1)
`define DMH_TIMEOUT_S    7'd100
`define DMH_FREQ_W       19
`define DMH_FRAC_W       12
`define DMH_SHIFT_SHORT  6
`define DMH_SHIFT_LONG   10
`define DMH_ADDR_W       4
`define DMH_OFS_CFG      4'h0
`define DMH_OFS_HOFS     4'h4
`define DMH_OFS_LIVE     4'h8
`define DMH_OFS_STS      4'hc
`define DMH_CFG_MAN      0
`define DMH_CFG_AVG      1
`define DMH_CFG_SHORT    2
`define DMH_CFG_RDAVG    3
`define DMH_CFG_MINI_LO  4
`define DMH_CFG_REVERT   6
`define DMH_CFG_RST      7'h00
`define DMH_STS_ALARM    3
`define DMH_STS_MINI     4
`define DMH_CODE_FREE    3'h1
`define DMH_CODE_HOLD    3'h2
`define DMH_CODE_LOCK    3'h4
`define DMH_CODE_LOST    3'h5
`define DMH_CODE_PRE     3'h6
`define DMH_CODE_PRE2    3'h7
`endif

// File: rtl/dmh_ctrl_pkg.sv
// Types for the main-loop mode and holdover controller
`default_nettype none
package dmh_ctrl_pkg;
  typedef enum logic [5:0] {
    ST_FREE = 6'h01,
    ST_PRE  = 6'h02,
    ST_LOCK = 6'h04,
    ST_LOST = 6'h08,
    ST_HOLD = 6'h10,
    ST_PRE2 = 6'h20
  } dmh_state_type;
  typedef enum logic [1:0] {
    MINI_INTEG  = 2'h0,
    MINI_AVG    = 2'h1,
    MINI_MANUAL = 2'h2,
    MINI_ZERO   = 2'h3
  } dmh_mini_type;
endpackage : dmh_ctrl_pkg
`default_nettype wire

// File: rtl/dmh_ctrl.sv
// Main-loop operating-mode state machine with holdover frequency control
`include "dmh_ctrl_consts.svh"
`default_nettype none
module dmh_ctrl #(
  parameter int SEC_CYCLES = `DMH_SEC_CYCLES,
  parameter int AVG_CYCLES = `DMH_SEC_CYCLES,
  parameter int FW         = `DMH_FREQ_W
) (
  // Clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    clk_en,
  // Register port
  input  wire logic [`DMH_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // Selector and detector events
  input  wire logic                    ref_selected,
  input  wire logic                    phase_lock,
  input  wire logic                    bucket_trig,
  input  wire logic                    standby_good,
  input  wire logic                    ref_invalid,
  input  wire logic                    higher_prio_restored,
  input  wire logic                    ref_missing,
  input  wire logic                    new_source,
  input  wire logic signed [FW-1:0]    integ_freq,
  // Loop control outputs
  output logic      [2:0]              main_loop_state_code,
  output logic signed [FW-1:0]         freq_ctrl,
  output logic                         freq_override,
  output logic                         mini_holdover,
  output logic                         phase_alarm,
  output logic                         disqualify,
  output logic                         reselect_req
);

  localparam int PW = $clog2(SEC_CYCLES + 1);
  localparam int AW = $clog2(AVG_CYCLES + 1);
  localparam int FR = `DMH_FRAC_W;
  localparam int XW = FW + FR;

  if (SEC_CYCLES < 2 || AVG_CYCLES < 2 || FW < 8) begin : g_chk
    $error("dmh_ctrl: parameter values not supported");
  end

  // Reads sign-extend the frequency word into the 32-bit read port
  if (FW > 32) begin : g_fw_chk
    $error("dmh_ctrl: frequency word wider than the read port");
  end

  dmh_ctrl_pkg::dmh_state_type st_q;
  dmh_ctrl_pkg::dmh_state_type st_d;

  logic [6:0]              cfg_q;
  logic signed [FW-1:0]    hofs_q;
  logic signed [FW-1:0]    frozen_q;
  logic signed [FW-1:0]    mini_val_q;
  logic signed [XW-1:0]    acc_q;
  logic [PW-1:0]           pre_q;
  logic [PW-1:0]           lock_cnt_q;
  logic [AW-1:0]           avg_pre_q;
  logic [6:0]              sec_q;
  logic                    mini_q;
  logic                    alarm_q;
  logic                    disq_q;
  logic                    resel_q;
  logic [2:0]              code_q;
  logic signed [FW-1:0]    freq_q;
  logic                    ovr_q;
  logic [31:0]             rdata_q;

  logic                    entry;
  logic                    sec_tick;
  logic                    timeout;
  logic                    lock_ok;
  logic                    lock_full;
  logic                    lost_disq;
  logic                    lost_tmo;
  logic                    retry_tmo;
  logic                    hold_entry;
  logic                    avg_tick;
  logic signed [FW-1:0]    avg_val;
  logic signed [XW-1:0]    diff;
  logic signed [XW-1:0]    step;
  logic                    man_mode;
  logic                    avg_mode;
  logic                    revertive;
  logic                    wr_cfg;
  logic                    wr_hofs;
  logic                    wr_sts;
  dmh_ctrl_pkg::dmh_mini_type mini_sel;

  assign man_mode  = cfg_q[`DMH_CFG_MAN];
  assign avg_mode  = cfg_q[`DMH_CFG_AVG];
  assign revertive = cfg_q[`DMH_CFG_REVERT];
  assign mini_sel  = dmh_ctrl_pkg::dmh_mini_type'(cfg_q[`DMH_CFG_MINI_LO +: 2]);

  // Write strobes decoded once so every register sees the same address compare
  assign wr_cfg  = reg_wr && (reg_addr == `DMH_OFS_CFG);
  assign wr_hofs = reg_wr && (reg_addr == `DMH_OFS_HOFS);
  assign wr_sts  = reg_wr && (reg_addr == `DMH_OFS_STS);

  // Timers restart on every state change so each state sees a fresh window
  assign entry    = (st_d != st_q);
  assign sec_tick = (pre_q == PW'(SEC_CYCLES - 1));
  assign timeout  = sec_tick && (sec_q == `DMH_TIMEOUT_S);
  assign lock_full = (lock_cnt_q == PW'(SEC_CYCLES));
  // A break in the very cycle the count completes must still deny lock
  assign lock_ok  = lock_full && phase_lock && ref_selected;
  assign lost_tmo = (st_q == dmh_ctrl_pkg::ST_LOST) && timeout;
  assign lost_disq = (st_q == dmh_ctrl_pkg::ST_LOST) && (bucket_trig || timeout);
  assign retry_tmo = timeout && !lock_ok && (st_q == dmh_ctrl_pkg::ST_PRE ||
                                             st_q == dmh_ctrl_pkg::ST_PRE2);
  assign hold_entry = (st_d == dmh_ctrl_pkg::ST_HOLD) && (st_q != dmh_ctrl_pkg::ST_HOLD);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= '0;
      sec_q <= 7'h00;
    end else if (clk_en) begin
      if (entry || sec_tick) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + PW'(1);
      end
      if (entry) begin
        sec_q <= 7'h00;
      end else if (sec_tick && sec_q != 7'h7f) begin
        sec_q <= sec_q + 7'h01;
      end
    end
  end

  // Any break in lock restarts the one-second qualification
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt_q <= '0;
    end else if (clk_en) begin
      if (entry || !phase_lock || !ref_selected) begin
        lock_cnt_q <= '0;
      end else if (!lock_full) begin
        lock_cnt_q <= lock_cnt_q + PW'(1);
      end
    end
  end

  // Next state; an invalid reference outranks a plain phase loss in locked
  always_comb begin
    st_d = st_q;
    case (st_q)
      dmh_ctrl_pkg::ST_FREE: begin
        if (ref_selected) begin
          st_d = dmh_ctrl_pkg::ST_PRE;
        end
      end
      dmh_ctrl_pkg::ST_PRE: begin
        if (lock_ok) begin
          st_d = dmh_ctrl_pkg::ST_LOCK;
        end else if (timeout) begin
          st_d = dmh_ctrl_pkg::ST_FREE;
        end
      end
      dmh_ctrl_pkg::ST_LOCK: begin
        if (ref_invalid) begin
          st_d = standby_good ? dmh_ctrl_pkg::ST_PRE2 : dmh_ctrl_pkg::ST_HOLD;
        end else if (!phase_lock) begin
          st_d = dmh_ctrl_pkg::ST_LOST;
        end else if (revertive && higher_prio_restored) begin
          st_d = dmh_ctrl_pkg::ST_PRE2;
        end
      end
      dmh_ctrl_pkg::ST_LOST: begin
        if (lost_disq || ref_invalid) begin
          st_d = standby_good ? dmh_ctrl_pkg::ST_PRE2 : dmh_ctrl_pkg::ST_HOLD;
        end else if (phase_lock && ref_selected) begin
          st_d = dmh_ctrl_pkg::ST_LOCK;
        end
      end
      dmh_ctrl_pkg::ST_HOLD: begin
        if (ref_selected || (revertive && higher_prio_restored)) begin
          st_d = dmh_ctrl_pkg::ST_PRE2;
        end
      end
      dmh_ctrl_pkg::ST_PRE2: begin
        if (lock_ok) begin
          st_d = dmh_ctrl_pkg::ST_LOCK;
        end else if (timeout) begin
          st_d = dmh_ctrl_pkg::ST_HOLD;
        end
      end
      default: begin
        st_d = dmh_ctrl_pkg::ST_FREE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= dmh_ctrl_pkg::ST_FREE;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Code follows the next state so that it changes on the same edge as the state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_q <= `DMH_CODE_FREE;
    end else if (clk_en) begin
      case (st_d)
        dmh_ctrl_pkg::ST_PRE:  code_q <= `DMH_CODE_PRE;
        dmh_ctrl_pkg::ST_LOCK: code_q <= `DMH_CODE_LOCK;
        dmh_ctrl_pkg::ST_LOST: code_q <= `DMH_CODE_LOST;
        dmh_ctrl_pkg::ST_HOLD: code_q <= `DMH_CODE_HOLD;
        dmh_ctrl_pkg::ST_PRE2: code_q <= `DMH_CODE_PRE2;
        default:               code_q <= `DMH_CODE_FREE;
      endcase
    end
  end

  // Event pulses towards the source selector
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disq_q  <= 1'b0;
      resel_q <= 1'b0;
    end else if (clk_en) begin
      disq_q  <= lost_disq;
      resel_q <= retry_tmo;
    end
  end

  // Alarm is sticky; a new timeout beats a software clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_q <= 1'b0;
    end else if (clk_en) begin
      if (lost_tmo) begin
        alarm_q <= 1'b1;
      end else if (wr_sts && reg_wdata[`DMH_STS_ALARM]) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // Integral value, or the mini-holdover value if mini-holdover is active, captured at holdover entry; proportional path never reaches here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frozen_q <= '0;
    end else if (clk_en) begin
      if (hold_entry) begin
        frozen_q <= mini_q ? mini_val_q : integ_freq;
      end
    end
  end

  // Leaky IIR; fractional bits keep small differences from stalling the filter
  assign diff    = (XW'(integ_freq) <<< FR) - acc_q;
  assign step    = cfg_q[`DMH_CFG_SHORT] ? (diff >>> `DMH_SHIFT_SHORT)
                                         : (diff >>> `DMH_SHIFT_LONG);
  assign avg_val = acc_q[XW-1:FR];
  assign avg_tick = (avg_pre_q == AW'(AVG_CYCLES - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avg_pre_q <= '0;
      acc_q     <= '0;
    end else if (clk_en) begin
      avg_pre_q <= avg_tick ? '0 : avg_pre_q + AW'(1);
      // Averaging stops while the input is untrustworthy
      if (avg_tick && !mini_q && st_q != dmh_ctrl_pkg::ST_HOLD &&
          st_q != dmh_ctrl_pkg::ST_FREE) begin
        acc_q <= acc_q + step;
      end
    end
  end

  // Mini-holdover freezes on the first missing-clock report
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mini_q     <= 1'b0;
      mini_val_q <= '0;
    end else if (clk_en) begin
      if (mini_q) begin
        if (new_source || !ref_missing || st_d == dmh_ctrl_pkg::ST_HOLD) begin
          mini_q <= 1'b0;
        end
      end else if (ref_missing && st_q != dmh_ctrl_pkg::ST_HOLD &&
                   st_q != dmh_ctrl_pkg::ST_FREE && !new_source) begin
        mini_q <= 1'b1;
        case (mini_sel)
          dmh_ctrl_pkg::MINI_INTEG:  mini_val_q <= integ_freq;
          dmh_ctrl_pkg::MINI_AVG:    mini_val_q <= avg_val;
          dmh_ctrl_pkg::MINI_MANUAL: mini_val_q <= hofs_q;
          default:                   mini_val_q <= '0;
        endcase
      end
    end
  end

  // Frequency word handed to the loop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freq_q <= '0;
      ovr_q  <= 1'b0;
    end else if (clk_en) begin
      if (st_q == dmh_ctrl_pkg::ST_HOLD) begin
        ovr_q <= 1'b1;
        if (man_mode) begin
          freq_q <= hofs_q;
        end else if (avg_mode) begin
          freq_q <= avg_val;
        end else begin
          freq_q <= frozen_q;
        end
      end else if (mini_q) begin
        ovr_q  <= 1'b1;
        freq_q <= mini_val_q;
      end else begin
        ovr_q  <= 1'b0;
        freq_q <= integ_freq;
      end
    end
  end

  // Register writes; a running host loop may rewrite the offset at any time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= `DMH_CFG_RST;
    end else if (clk_en && wr_cfg) begin
      cfg_q <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hofs_q <= '0;
    end else if (clk_en && wr_hofs) begin
      hofs_q <= reg_wdata[FW-1:0];
    end
  end

  // Read data stand for one cycle only; idle cycles return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `DMH_OFS_CFG:  rdata_q <= {25'h0, cfg_q};
          `DMH_OFS_HOFS: rdata_q <= 32'(signed'(cfg_q[`DMH_CFG_RDAVG] ? avg_val : hofs_q));
          `DMH_OFS_LIVE: rdata_q <= 32'(signed'(integ_freq));
          `DMH_OFS_STS:  rdata_q <= {27'h0, mini_q, alarm_q, code_q};
          default:       rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Every output is a register
  assign reg_rdata            = rdata_q;
  assign main_loop_state_code = code_q;
  assign freq_ctrl            = freq_q;
  assign freq_override        = ovr_q;
  assign mini_holdover        = mini_q;
  assign phase_alarm          = alarm_q;
  assign disqualify           = disq_q;
  assign reselect_req         = resel_q;

endmodule : dmh_ctrl
`default_nettype wire

// File: testbench/dmh_ctrl_checker.sv
// Port-level assertions for the mode controller
`include "dmh_ctrl_consts.svh"
`default_nettype none
module dmh_ctrl_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  // Events
  input wire logic       ref_selected,
  input wire logic       phase_lock,
  input wire logic       standby_good,
  input wire logic       ref_invalid,
  input wire logic       higher_prio_restored,
  input wire logic       ref_missing,
  input wire logic       new_source,
  // Status
  input wire logic [2:0] main_loop_state_code,
  input wire logic       mini_holdover,
  input wire logic       disqualify,
  input wire logic       reselect_req
);
  wire logic [2:0] st = main_loop_state_code;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_lock_entry: assert property (st == `DMH_CODE_LOCK && $changed(st) |->
    $past(st) inside {`DMH_CODE_PRE, `DMH_CODE_PRE2, `DMH_CODE_LOST}) else $error("bad lock entry");
  a_lock_cause: assert property (st == `DMH_CODE_LOCK && $changed(st) |->
    $past(phase_lock) && $past(ref_selected)) else $error("lock without cause");
  a_lost_entry: assert property (st == `DMH_CODE_LOCK && clk_en && !phase_lock && !ref_invalid
    && !higher_prio_restored |=> st == `DMH_CODE_LOST) else $error("no lost-phase entry");
  a_disq_target: assert property (disqualify |-> $past(st) == `DMH_CODE_LOST &&
    st == ($past(standby_good) ? `DMH_CODE_PRE2 : `DMH_CODE_HOLD)) else $error("bad disqualify");
  a_disq_pulse: assert property (disqualify |=> !disqualify) else $error("long disqualify");
  a_free_exit: assert property (st == `DMH_CODE_FREE && clk_en && ref_selected
    |=> st == `DMH_CODE_PRE) else $error("free-run not left");
  a_hold_exit: assert property (st == `DMH_CODE_HOLD && clk_en && ref_selected
    |=> st == `DMH_CODE_PRE2) else $error("holdover not left");
  a_retry_pulse: assert property (reselect_req |->
    ($past(st) == `DMH_CODE_PRE && st == `DMH_CODE_FREE) ||
    ($past(st) == `DMH_CODE_PRE2 && st == `DMH_CODE_HOLD)) else $error("bad reselect");
  a_invalid_lock: assert property (st == `DMH_CODE_LOCK && clk_en && ref_invalid |=>
    st == ($past(standby_good) ? `DMH_CODE_PRE2 : `DMH_CODE_HOLD)) else $error("bad invalid exit");
  a_mini_end: assert property (mini_holdover && clk_en && (new_source || !ref_missing)
    |=> !mini_holdover) else $error("mini not ended");
  a_mini_start: assert property (st == `DMH_CODE_LOCK && clk_en && ref_missing && !new_source
    && phase_lock && !ref_invalid && !higher_prio_restored |=> mini_holdover)
    else $error("mini not entered");
endmodule : dmh_ctrl_checker
bind dmh_ctrl dmh_ctrl_checker u_chk (.clk(clk), .nrst(nrst), .clk_en(clk_en),
  .ref_selected(ref_selected), .phase_lock(phase_lock), .standby_good(standby_good),
  .ref_invalid(ref_invalid), .higher_prio_restored(higher_prio_restored),
  .ref_missing(ref_missing), .new_source(new_source),
  .main_loop_state_code(main_loop_state_code), .mini_holdover(mini_holdover),
  .disqualify(disqualify), .reselect_req(reselect_req));
`default_nettype wire

// File: testbench/test_dmh_ctrl.sv
// Self-checking bench for the mode controller
`include "dmh_ctrl_consts.svh"
`default_nettype none
module test_dmh_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  // Short second so that 100 s timeouts stay a few hundred cycles
  localparam int SEC = 4;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic               clk_en = 1'b1;
  logic [3:0]         reg_addr = 4'h0;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata;
  logic               ref_selected = 1'b0;
  logic               phase_lock = 1'b0;
  logic               bucket_trig = 1'b0;
  logic               standby_good = 1'b0;
  logic               ref_invalid = 1'b0;
  logic               higher_prio_restored = 1'b0;
  logic               ref_missing = 1'b0;
  logic               new_source = 1'b0;
  logic signed [18:0] integ_freq = 19'sh0;
  logic [2:0]         main_loop_state_code;
  logic signed [18:0] freq_ctrl;
  logic               freq_override, mini_holdover, phase_alarm, disqualify, reselect_req;
  logic [18:0]        mexp [4] = '{19'h4abcd, 19'h0, 19'h01234, 19'h0};
  int                 failures = 0;
  int                 comparisons = 0;
  int                 cycles = 0;

  dmh_ctrl #(.SEC_CYCLES(SEC), .AVG_CYCLES(SEC)) dut (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ref_selected(ref_selected), .phase_lock(phase_lock),
    .bucket_trig(bucket_trig), .standby_good(standby_good), .ref_invalid(ref_invalid),
    .higher_prio_restored(higher_prio_restored), .ref_missing(ref_missing),
    .new_source(new_source), .integ_freq(integ_freq),
    .main_loop_state_code(main_loop_state_code), .freq_ctrl(freq_ctrl),
    .freq_override(freq_override), .mini_holdover(mini_holdover),
    .phase_alarm(phase_alarm), .disqualify(disqualify), .reselect_req(reselect_req));

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic wc(input logic [2:0] e, input int n);
    #1;
    for (int i = 0; i < n && main_loop_state_code !== e; i++) @(posedge clk) #1;
    chk("state_code", {29'h0, e}, {29'h0, main_loop_state_code});
  endtask : wc
  task automatic cf(input logic [18:0] e);
    chk("freq_ctrl", {13'h0, e}, {13'h0, freq_ctrl});
  endtask : cf
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask : go

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      wrap_up;
    end
  end

  initial begin
    go(2);
    nrst <= 1'b1;
    wc(`DMH_CODE_FREE, 0);
    chk("flags", 32'h0, {27'h0, freq_override, mini_holdover, phase_alarm, disqualify, reselect_req});
    rd(4'h0, 32'h0);
    rd(4'h2, 32'h0);
    // Averager is idle in free-run, so filtered readback shows zero
    wr(4'h4, 32'h00555);
    wr(4'h0, 32'h08);
    rd(4'h4, 32'h0);
    wr(4'h0, 32'h0);
    rd(4'h4, 32'h00555);
    @(posedge clk);
    ref_selected <= 1'b1;
    wc(`DMH_CODE_PRE, 3);
    wc(`DMH_CODE_FREE, 120 * SEC);
    chk("reselect_req", 32'h1, {31'h0, reselect_req});
    @(posedge clk);
    phase_lock <= 1'b1;
    go(2);
    wc(`DMH_CODE_PRE, 0);
    wc(`DMH_CODE_LOCK, 3 * SEC);
    rd(4'hc, {29'h0, `DMH_CODE_LOCK});
    @(posedge clk);
    phase_lock <= 1'b0;
    wc(`DMH_CODE_LOST, 3);
    @(posedge clk);
    phase_lock <= 1'b1;
    wc(`DMH_CODE_LOCK, 3);
    @(posedge clk);
    phase_lock <= 1'b0;
    standby_good <= 1'b1;
    wc(`DMH_CODE_LOST, 3);
    @(posedge clk);
    bucket_trig <= 1'b1;
    @(posedge clk);
    bucket_trig <= 1'b0;
    wc(`DMH_CODE_PRE2, 2);
    chk("disqualify", 32'h1, {31'h0, disqualify});
    @(posedge clk);
    phase_lock <= 1'b1;
    integ_freq <= 19'sh4abcd;
    wc(`DMH_CODE_LOCK, 3 * SEC);
    rd(4'h8, 32'hfffcabcd);
    wr(4'h4, 32'h01234);
    // Method 1 follows the averager, whose value is not pinned down here
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, {26'h0, 2'(m), 4'h0});
      @(posedge clk);
      ref_missing <= 1'b1;
      go(2);
      #1 chk("mini_holdover", 32'h1, {31'h0, mini_holdover});
      if (m != 1) cf(mexp[m]);
      @(posedge clk);
      ref_missing <= 1'b0;
      go(2);
      #1 chk("mini_holdover", 32'h0, {31'h0, mini_holdover});
    end
    @(posedge clk);
    phase_lock <= 1'b0;
    ref_selected <= 1'b0;
    standby_good <= 1'b0;
    wc(`DMH_CODE_LOST, 3);
    wc(`DMH_CODE_HOLD, 120 * SEC);
    chk("phase_alarm", 32'h1, {31'h0, phase_alarm});
    rd(4'hc, 32'h0a);
    wr(4'hc, 32'h8);
    rd(4'hc, 32'h02);
    chk("phase_alarm", 32'h0, {31'h0, phase_alarm});
    @(posedge clk);
    integ_freq <= 19'sh00111;
    go(2);
    #1 cf(19'h4abcd);
    chk("freq_override", 32'h1, {31'h0, freq_override});
    wr(4'h0, 32'h41);
    go(1);
    #1 cf(19'h01234);
    @(posedge clk);
    higher_prio_restored <= 1'b1;
    @(posedge clk);
    higher_prio_restored <= 1'b0;
    wc(`DMH_CODE_PRE2, 2);
    wc(`DMH_CODE_HOLD, 120 * SEC);
    chk("reselect_req", 32'h1, {31'h0, reselect_req});
    @(posedge clk);
    ref_selected <= 1'b1;
    phase_lock <= 1'b1;
    wc(`DMH_CODE_PRE2, 3);
    wc(`DMH_CODE_LOCK, 3 * SEC);
    // With the enable low an invalid reference must leave the state untouched
    @(posedge clk);
    clk_en <= 1'b0;
    ref_invalid <= 1'b1;
    go(2);
    #1 chk("state_code", {29'h0, `DMH_CODE_LOCK}, {29'h0, main_loop_state_code});
    @(posedge clk);
    clk_en <= 1'b1;
    ref_invalid <= 1'b0;
    @(posedge clk);
    ref_invalid <= 1'b1;
    @(posedge clk);
    ref_invalid <= 1'b0;
    wc(`DMH_CODE_HOLD, 2);
    @(posedge clk);
    nrst <= 1'b0;
    go(2);
    wc(`DMH_CODE_FREE, 0);
    wrap_up;
  end
endmodule : test_dmh_ctrl
`default_nettype wire
